/* swc_pkg.sv */
// package for the sampling-window capture block
package swc_pkg;
   // ------------------------------------------------------------
   // sizes and register map
   // ------------------------------------------------------------
   localparam int NUM_POS = 24;
   localparam int NUM_SEL = 16;
   localparam int SEL_W = 4;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_POS_LOW = 12'h002c;
   localparam logic [ADDR_W-1:0] ADDR_POS_MID = 12'h002d;
   localparam logic [ADDR_W-1:0] ADDR_POS_HIGH = 12'h002e;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h002f;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_ZOOM_BIT = 4;
   localparam logic [SEL_W-1:0] RST_SEL = 4'h0;
   localparam logic RST_ZOOM = 1'b1;
   localparam logic [NUM_POS-1:0] RST_POS = 24'hff_ffff;
   localparam int EDGE_POS = NUM_POS - 1;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } swc_req_type;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } swc_rsp_type;
endpackage : swc_pkg

/* swc_tap.sv */
// one delay-tap sampler: marks a tap unsafe when two sample phases disagree
`timescale 1ns/1ps
module swc_tap
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_en,
   input wire logic i_early,
   input wire logic i_late,
   output logic o_unsafe
);
   import swc_pkg::*;
   logic next_unsafe;

   // ------------------------------------------------------------
   // violation detect
   // ------------------------------------------------------------
   // early and late neighbours disagree: edge sits inside this tap's margin
   always_comb
   begin
      next_unsafe = i_early ^ i_late;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_unsafe <= 1'b1;
      else if (i_en)
         o_unsafe <= next_unsafe;
   end
endmodule : swc_tap

/* swc_top.sv */
// sysref window capture: position detector, select, register port
`timescale 1ns/1ps
// Summary of operation
// - sysref latched on one chosen clock edge
// - locate sysref against device clock edge
// - status holds one bit per position
// - one marks risky position, zero valid
// - capture instant is selected delayed tap
// - step control picks coarse or fine spacing
// - status bits zero and 23 forced one
// - select value is plain bit index
// - select reaches only positions 0 to 15
// - status bits above 15 informational only
module swc_top
#(
   parameter int NUM_POS_P = swc_pkg::NUM_POS
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic [swc_pkg::NUM_POS-1:0] i_tap_fine,
   input wire logic [swc_pkg::NUM_POS-1:0] i_tap_coarse,
   input wire swc_pkg::swc_req_type i_req,
   output swc_pkg::swc_rsp_type o_rsp,
   output logic o_fine_delay_step,
   output logic o_sysref_captured,
   output logic [swc_pkg::NUM_POS-1:0] o_capture_position_status
);
   import swc_pkg::*;

   // ------------------------------------------------------------
   // tap inputs cross from the delay line: two flops each
   // ------------------------------------------------------------
   logic [NUM_POS-1:0] sync1_fine;
   logic [NUM_POS-1:0] sync1_coarse;
   logic [NUM_POS-1:0] sync2_fine;
   logic [NUM_POS-1:0] sync2_coarse;
   logic [NUM_POS-1:0] taps;
   logic [NUM_POS-1:0] unsafe;
   logic [NUM_POS-1:0] next_pos;
   logic [NUM_POS-1:0] pos;
   logic [SEL_W-1:0] sel;
   logic [SEL_W-1:0] next_sel;
   logic zoom;
   logic next_zoom;
   logic cap;
   logic next_cap;
   logic cap_prev;
   swc_rsp_type rsp;
   swc_rsp_type next_rsp;

   // both delay lines are synchronised on their own; the step mux sits
   // after the second flop so no pin value reaches logic unsettled
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sync1_fine <= '0;
         sync1_coarse <= '0;
         sync2_fine <= '0;
         sync2_coarse <= '0;
      end
      else if (i_ce)
      begin
         sync1_fine <= i_tap_fine;
         sync1_coarse <= i_tap_coarse;
         sync2_fine <= sync1_fine;
         sync2_coarse <= sync1_coarse;
      end
   end

   // step control chooses which delay line feeds the detector
   always_comb
   begin
      taps = zoom ? sync2_fine : sync2_coarse;
   end

   // ------------------------------------------------------------
   // per-tap detectors, ends have no neighbour so stay flagged
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_POS; g++)
      begin : g_tap
         if (g == 0 || g == EDGE_POS)
         begin : g_edge
            assign unsafe[g] = 1'b1;
         end
         else
         begin : g_mid
            swc_tap u_tap
            (
               .i_clk(i_clk),
               .i_nrst(i_nrst),
               .i_en(i_ce),
               .i_early(taps[g-1]),
               .i_late(taps[g+1]),
               .o_unsafe(unsafe[g])
            );
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // status refresh and capture
   // ------------------------------------------------------------
   // status updates every clock-enabled cycle; no write path reaches it
   always_comb
   begin
      next_pos = unsafe;
      next_pos[0] = 1'b1;
      next_pos[EDGE_POS] = 1'b1;
      // only taps 0..15 are selectable, index is the plain bit number
      next_cap = taps[{1'b0, sel}];
   end

   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   always_comb
   begin
      next_sel = sel;
      next_zoom = zoom;
      next_rsp = '0;
      if (i_req.wr && i_req.addr == ADDR_CTRL)
      begin
         next_sel = i_req.wdata[CTRL_SEL_LSB +: SEL_W];
         next_zoom = i_req.wdata[CTRL_ZOOM_BIT];
      end
      if (i_req.rd)
      begin
         next_rsp.valid = 1'b1;
         case (i_req.addr)
            ADDR_POS_LOW: next_rsp.rdata = pos[7:0];
            ADDR_POS_MID: next_rsp.rdata = pos[15:8];
            ADDR_POS_HIGH: next_rsp.rdata = pos[23:16];
            ADDR_CTRL: next_rsp.rdata = {3'b000, zoom, sel};
            default: next_rsp.rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         pos <= RST_POS;
         sel <= RST_SEL;
         zoom <= RST_ZOOM;
         cap <= 1'b0;
         cap_prev <= 1'b0;
         rsp <= '0;
      end
      else if (i_ce)
      begin
         pos <= next_pos;
         sel <= next_sel;
         zoom <= next_zoom;
         cap <= next_cap;
         cap_prev <= cap;
         rsp <= next_rsp;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // captured pulse marks the rising sample at the chosen tap
   logic cap_pulse;
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         cap_pulse <= 1'b0;
      else if (i_ce)
         cap_pulse <= cap & ~cap_prev;
   end
   assign o_sysref_captured = cap_pulse;
   assign o_rsp = rsp;
   assign o_fine_delay_step = zoom;
   assign o_capture_position_status = pos;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // end bits carry no margin information and must stay flagged
   edge_bits_a: assert property (pos[0] && pos[EDGE_POS])
      else $error("edge status bits not set");
   status_ro_a: assert property (
      i_ce |=> pos == ($past(unsafe) | {1'b1, {(NUM_POS - 2){1'b0}}, 1'b1}))
      else $error("status not refreshed from detector");
   sel_write_a: assert property (
      i_ce && i_req.wr && i_req.addr == ADDR_CTRL
      |=> sel == $past(i_req.wdata[3:0]))
      else $error("select write lost");
   zoom_write_a: assert property (
      i_ce && i_req.wr && i_req.addr == ADDR_CTRL
      |=> zoom == $past(i_req.wdata[4]))
      else $error("step control write lost");
   cap_tap_a: assert property (i_ce |=> cap == $past(taps[sel]))
      else $error("capture not from selected tap");
   read_low_a: assert property (
      i_ce && i_req.rd && i_req.addr == ADDR_POS_LOW
      |=> rsp.valid && rsp.rdata == $past(pos[7:0]))
      else $error("status low read wrong");
   read_gap_a: assert property (
      i_ce && i_req.rd && i_req.addr > ADDR_CTRL
      |=> rsp.valid && rsp.rdata == 8'h00)
      else $error("unmapped read not zero");
   no_rd_a: assert property (i_ce && !i_req.rd |=> !rsp.valid)
      else $error("spurious read answer");
   // clock enable low must freeze status and control alike
   ce_hold_a: assert property (
      !i_ce |=> $stable(pos) && $stable(sel) && $stable(zoom))
      else $error("state moved with clock enable low");
   cap_fine_c: cover property (i_ce && zoom ##1 cap_pulse);
   cap_coarse_c: cover property (i_ce && !zoom ##1 cap_pulse);
   sel_hi_c: cover property (sel == 4'hf && cap);
   ce_hold_c: cover property (!i_ce ##1 i_ce);
endmodule : swc_top

/* swc_clk_src.sv */
// far-side model: sysref as seen at the delayed clock taps
`timescale 1ns/1ps
module swc_clk_src
(
   input wire logic i_on,
   input wire logic [4:0] i_edge,
   output logic [swc_pkg::NUM_POS-1:0] o_tap_fine,
   output logic [swc_pkg::NUM_POS-1:0] o_tap_coarse
);
   import swc_pkg::*;
   // sysref is one long pulse, so no period relation is at stake
   // coarse taps are wider, so the same edge lands at half the index
   always_comb
   begin
      for (int i = 0; i < NUM_POS; i++)
      begin
         o_tap_fine[i] = i_on && (i >= int'(i_edge));
         o_tap_coarse[i] = i_on && (i >= int'(i_edge >> 1));
      end
   end
endmodule : swc_clk_src

/* tb_top.sv */
// self-checking bench for the sysref window capture block
`timescale 1ns/1ps
module tb_top;
   import swc_pkg::*;
   typedef struct packed {
      logic stp;
      logic [4:0] e;
      logic [23:0] st;
   } swc_row_type;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic src_on = 1'b0;
   logic ce = 1'b1;
   int k;
   logic [4:0] edge_pos = 5'h06;
   logic [NUM_POS-1:0] tap_f, tap_c, status;
   swc_req_type req = '0;
   swc_rsp_type rsp;
   logic step, capt;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   logic [7:0] d;
   logic [23:0] s;
   swc_row_type rows [5] = '{'{1'b1, 5'h06, 24'h80_0061},
      '{1'b1, 5'h0e, 24'h80_6001}, '{1'b0, 5'h14, 24'h80_0601},
      '{1'b0, 5'h06, 24'h80_000d}, '{1'b1, 5'h14, 24'h98_0001}};
   logic [7:0] ctl_tab [4] = '{8'h18, 8'h13, 8'h1f, 8'h05};
   int pulse_tab [4] = '{1, 0, 1, 1};

   swc_clk_src i_src (.i_on(src_on), .i_edge(edge_pos),
      .o_tap_fine(tap_f), .o_tap_coarse(tap_c));
   swc_top #(.NUM_POS_P(NUM_POS)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_ce(ce), .i_tap_fine(tap_f), .i_tap_coarse(tap_c), .i_req(req),
      .o_rsp(rsp), .o_fine_delay_step(step), .o_sysref_captured(capt),
      .o_capture_position_status(status));

   // ----------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------
   always #5 i_clk = ~i_clk;

   // the whole run needs well under 400 cycles
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_errors++;
         final_report();
      end
   end

   task final_report();
      if (n_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task chk(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge i_clk);
      #1 req = {1'b1, 1'b0, a, v};
      @(posedge i_clk);
      #1 req = '0;
   endtask : wr

   // answer is valid for the single cycle after the request edge
   task rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
      @(posedge i_clk);
      #1 req = {1'b0, 1'b1, a, 8'h00};
      @(posedge i_clk);
      #1 req = '0;
      chk({23'h00_0000, rsp.valid}, 24'h00_0001);
      v = rsp.rdata;
   endtask : rd

   task rd_st(output logic [23:0] v);
      rd(ADDR_POS_LOW, v[7:0]);
      rd(ADDR_POS_MID, v[15:8]);
      rd(ADDR_POS_HIGH, v[23:16]);
   endtask : rd_st

   task count_pulses(output int c);
      c = 0;
      repeat (10)
      begin
         @(posedge i_clk);
         #1 c += (capt === 1'b1) ? 1 : 0;
      end
   endtask : count_pulses

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge i_clk);
      #1 chk(status, RST_POS);
      chk({23'h00_0000, step}, {23'h00_0000, RST_ZOOM});
      i_nrst = 1'b1;
      repeat (8) @(posedge i_clk);
      rd_st(s);
      chk(s, 24'h80_0001);
      // clock and sysref are applied before each status read
      foreach (rows[i])
      begin
         wr(ADDR_CTRL, {3'h0, rows[i].stp, 4'h0});
         edge_pos = rows[i].e;
         src_on = 1'b1;
         repeat (8) @(posedge i_clk);
         rd_st(s);
         chk(s, rows[i].st);
         chk(status, rows[i].st);
         chk({23'h00_0000, step}, {23'h00_0000, rows[i].stp});
      end
      // host picks the midpoint below the first flagged region, rounding low
      k = 1;
      while (k < NUM_POS && !s[k])
         k++;
      wr(ADDR_CTRL, {4'h1, 4'(k / 2)});
      rd(ADDR_CTRL, d);
      chk({16'h0000, d}, 24'h00_0019);
      // status is read-only: a write must leave it alone
      wr(ADDR_POS_LOW, 8'h00);
      rd(ADDR_POS_LOW, d);
      chk({16'h0000, d}, 24'h00_0001);
      rd(12'h030, d);
      chk({16'h0000, d}, 24'h00_0000);
      wr(ADDR_CTRL, 8'hff);
      rd(ADDR_CTRL, d);
      chk({16'h0000, d}, 24'h00_001f);
      // capture fires only when the selected tap sees sysref rise;
      // the last row captures on the coarse line
      edge_pos = 5'h06;
      foreach (ctl_tab[i])
      begin
         wr(ADDR_CTRL, ctl_tab[i]);
         src_on = 1'b0;
         repeat (6) @(posedge i_clk);
         #1 src_on = 1'b1;
         count_pulses(n);
         chk(24'(n), 24'(pulse_tab[i]));
      end
      // mid-run reset: control returns to defaults, host reloads select
      @(posedge i_clk);
      #1 i_nrst = 1'b0;
      @(posedge i_clk);
      #1 chk(status, RST_POS);
      chk({23'h00_0000, capt}, 24'h00_0000);
      chk({23'h00_0000, rsp.valid}, 24'h00_0000);
      i_nrst = 1'b1;
      rd(ADDR_CTRL, d);
      chk({16'h0000, d}, {19'h0_0000, RST_ZOOM, RST_SEL});
      wr(ADDR_CTRL, 8'h18);
      rd(ADDR_CTRL, d);
      chk({16'h0000, d}, 24'h00_0018);
      // a write while the clock enable is low must not land
      ce = 1'b0;
      wr(ADDR_CTRL, 8'h05);
      ce = 1'b1;
      rd(ADDR_CTRL, d);
      chk({16'h0000, d}, 24'h00_0018);
      final_report();
   end
endmodule : tb_top
